// [rtl/eis_pkg.sv]
// constants, field layout and bus carriers of the interrupt status collector
// assumes an axi4-lite master with 32-bit data and one outstanding access per direction
// What this block does
// - host writes one to a status bit; the device then clears that bit
// - software event bit 31 sets while software trigger is high; write one clears
// - bit 25 sets when stop is requested and transmitter has halted
// - bit 24 sets when the receive engine halts
// - bit 23 sets when drop counter steps into 80000000h
// - bit 21 sets when a notify-flagged transmit buffer finished loading
// - bit 20 sets when programmed receive dma count has been moved out
// - bit 19 sets when general timer wraps from zero to FFFFh
// - bit 18 mirrors transceiver event; writes ignored, clears at source only
// - bit 17 sets on power event regardless of wake pin; write one clears
// - power event never wakes; only a write to byte test register wakes
// - power event interrupt bypasses the deassertion hold-off interval
// - bit 16 sets when transmit status fifo overflows
// - bit 15 sets when a received packet exceeds 2048 bytes
// - bit 14 on receive error, bit 13 on transmit error; write one clears
// - bit 10 sets when a write hits a full transmit data fifo
// - bit 9 sets when transmit free space exceeds the programmed threshold
// - bit 8 sets when transmit status fifo becomes full
// - bit 7 sets when transmit status occupancy reaches the threshold
// - bit 6 sets each time a received frame is dropped
// - bit 4 on receive status fifo full, bit 3 on its level threshold
// - bits 2..0 latch the three io line events; reset to 000
// - a status bit reaches the request line only when its enable bit is one
// - status bits record events whatever the enable mask holds
// - global output enable clear keeps request pin deasserted, status untouched
package eis_pkg;
    localparam logic [7:0]  OFS_IRQ_CFG    = 8'h54;
    localparam logic [7:0]  OFS_STATUS     = 8'h58;
    localparam logic [7:0]  OFS_ENABLE     = 8'h5C;
    localparam logic [7:0]  OFS_BYTE_TEST  = 8'h64;
    localparam logic [31:0] BYTE_TEST_VAL  = 32'h87654321;
    localparam logic [31:0] STATUS_RST     = 32'h00000000;
    localparam logic [31:0] ENABLE_RST     = 32'h00000000;
    localparam logic [31:0] STATUS_IMPL    = 32'h83BFE7DF; // implemented status bits, 9 reserved
    localparam logic [31:0] STATUS_W1C     = 32'h83BBE7DF; // clearable bits, bit 18 excluded
    localparam logic [31:0] ENABLE_IMPL    = 32'h83BFE7DF;
    localparam logic [31:0] DROP_MIDPOINT  = 32'h80000000;
    localparam logic [15:0] TIMER_WRAP     = 16'hFFFF;
    localparam logic [15:0] RX_WATCHDOG_BYTES = 16'h0800;
    localparam int          BIT_SW    = 31;
    localparam int          BIT_TXSTP = 25;
    localparam int          BIT_RXSTP = 24;
    localparam int          BIT_DROPH = 23;
    localparam int          BIT_TXDON = 21;
    localparam int          BIT_RXDMA = 20;
    localparam int          BIT_TIMER = 19;
    localparam int          BIT_XCVR  = 18;
    localparam int          BIT_PWR   = 17;
    localparam int          BIT_TSOVF = 16;
    localparam int          BIT_RWDOG = 15;
    localparam int          BIT_RXERR = 14;
    localparam int          BIT_TXERR = 13;
    localparam int          BIT_TDOVR = 10;
    localparam int          BIT_TDAVL = 9;
    localparam int          BIT_TSFUL = 8;
    localparam int          BIT_TSLVL = 7;
    localparam int          BIT_DROP  = 6;
    localparam int          BIT_RSFUL = 4;
    localparam int          BIT_RSLVL = 3;
    localparam int          BIT_IRQ_EN  = 8;  // in interrupt configuration word
    localparam int          BIT_IRQ_INT = 12;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // event inputs from the surrounding units, each a level or one-cycle pulse
    typedef struct packed {
        logic        software_event_trigger;
        logic        tx_stop_requested;
        logic        tx_halted;
        logic        rx_halted;
        logic        drop_count_inc;
        logic [31:0] drop_count;          // value before the increment
        logic        transmit_buffer_loaded;
        logic        completion_notify_flag;
        logic        receive_dma_count_done;
        logic        timer_tick;
        logic [15:0] timer_count;         // value before the tick
        logic        transceiver_event;
        logic        power_event;
        logic        tx_status_overflow;
        logic        rx_packet_end;
        logic [15:0] rx_packet_bytes;
        logic        rx_error;
        logic        tx_error;
        logic        tx_data_write;
        logic        tx_data_full;
        logic        tx_space_above_level;
        logic        tx_status_full;
        logic        tx_status_at_level;
        logic        frame_dropped;
        logic        rx_status_full;
        logic        rx_status_at_level;
        logic [2:0]  io_line_events;
    } eis_events_s;

    // axi4-lite request and answer bundles
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } eis_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } eis_axi_rsp_s;
endpackage

// [rtl/eis_status.sv]
// interrupt status collector with enable mask and request output
// assumes event inputs synchronous to aclk; hold-off timer lives elsewhere
//
// The implementer's own choice: the AXI4-Lite slave port.
module eis_status (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire eis_pkg::eis_axi_req_s axi_req,
    output logic                       axi_awready,
    output logic                       axi_wready,
    output logic                       axi_bvalid,
    output logic [1:0]                 axi_bresp,
    output logic                       axi_arready,
    output logic                       axi_rvalid,
    output logic [31:0]                axi_rdata,
    output logic [1:0]                 axi_rresp,
    input  wire eis_pkg::eis_events_s  events,
    input  wire logic                  holdoff_active,
    output logic                       irq_request,
    output logic                       power_irq_request,
    output logic                       wake_request
);
    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] status;
        logic [31:0] enable;
        logic        irq_en;
        logic        irq;
        logic        pwr_irq;
        logic        wake;
    } eis_state_s;

    eis_state_s st_r;
    eis_state_s st_nxt;

    // byte-lane mask from write strobes
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == eis_pkg::OFS_IRQ_CFG) || (a == eis_pkg::OFS_STATUS) ||
                 (a == eis_pkg::OFS_ENABLE) || (a == eis_pkg::OFS_BYTE_TEST);
    endfunction

    logic [31:0] ev_set;
    logic [31:0] w1c;
    logic [31:0] wmask;
    logic [31:0] cfg_word;
    logic        do_write;
    logic        do_read;
    logic        any_irq;

    // gather hardware set terms; recorded regardless of the mask
    always_comb begin
        ev_set = 32'h00000000;
        ev_set[eis_pkg::BIT_SW]    = events.software_event_trigger;
        ev_set[eis_pkg::BIT_TXSTP] = events.tx_stop_requested & events.tx_halted;
        ev_set[eis_pkg::BIT_RXSTP] = events.rx_halted;
        ev_set[eis_pkg::BIT_DROPH] = events.drop_count_inc &
                                     (events.drop_count == eis_pkg::DROP_MIDPOINT - 32'h00000001);
        ev_set[eis_pkg::BIT_TXDON] = events.transmit_buffer_loaded & events.completion_notify_flag;
        ev_set[eis_pkg::BIT_RXDMA] = events.receive_dma_count_done;
        ev_set[eis_pkg::BIT_TIMER] = events.timer_tick & (events.timer_count == 16'h0000);
        ev_set[eis_pkg::BIT_PWR]   = events.power_event;
        ev_set[eis_pkg::BIT_TSOVF] = events.tx_status_overflow;
        ev_set[eis_pkg::BIT_RWDOG] = events.rx_packet_end &
                                     (events.rx_packet_bytes > eis_pkg::RX_WATCHDOG_BYTES);
        ev_set[eis_pkg::BIT_RXERR] = events.rx_error;
        ev_set[eis_pkg::BIT_TXERR] = events.tx_error;
        ev_set[eis_pkg::BIT_TDOVR] = events.tx_data_write & events.tx_data_full;
        ev_set[eis_pkg::BIT_TDAVL] = events.tx_space_above_level;
        ev_set[eis_pkg::BIT_TSFUL] = events.tx_status_full;
        ev_set[eis_pkg::BIT_TSLVL] = events.tx_status_at_level;
        ev_set[eis_pkg::BIT_DROP]  = events.frame_dropped;
        ev_set[eis_pkg::BIT_RSFUL] = events.rx_status_full;
        ev_set[eis_pkg::BIT_RSLVL] = events.rx_status_at_level;
        ev_set[2:0]                = events.io_line_events;
    end

    // write fires once both halves are held and no write answer is pending; read when no read answer is pending
    assign do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign do_read  = axi_req.arvalid && !st_r.rvalid;
    assign wmask    = lane_mask(st_r.w_strb);
    assign w1c      = (do_write && st_r.aw_addr == eis_pkg::OFS_STATUS) ?
                      (st_r.w_data & wmask & eis_pkg::STATUS_W1C) : 32'h00000000;

    // configuration word as software reads it
    always_comb begin
        cfg_word = 32'h00000000;
        cfg_word[eis_pkg::BIT_IRQ_EN]  = st_r.irq_en;
        cfg_word[eis_pkg::BIT_IRQ_INT] = any_irq;
    end

    assign any_irq = |(st_r.status & st_r.enable);

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // address and data accepted independently, in either order
        if (axi_req.awvalid && !st_r.aw_got) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = {axi_req.awaddr[7:2], 2'b00};
        end
        if (axi_req.wvalid && !st_r.w_got) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = axi_req.wdata;
            st_nxt.w_strb = axi_req.wstrb;
        end
        if (st_r.bvalid && axi_req.bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = mapped(st_r.aw_addr) ? eis_pkg::RESP_OKAY : eis_pkg::RESP_SLVERR;
            if (st_r.aw_addr == eis_pkg::OFS_ENABLE) begin
                st_nxt.enable = ((st_r.enable & ~wmask) | (st_r.w_data & wmask)) & eis_pkg::ENABLE_IMPL;
            end
            if (st_r.aw_addr == eis_pkg::OFS_IRQ_CFG && st_r.w_strb[1]) begin
                st_nxt.irq_en = st_r.w_data[eis_pkg::BIT_IRQ_EN];
            end
        end
        // wake only from a write cycle to byte test, never from a power event
        st_nxt.wake = do_write && (st_r.aw_addr == eis_pkg::OFS_BYTE_TEST);
        // clear, then set: an event in the clearing cycle survives
        st_nxt.status = (st_r.status & ~w1c) | (ev_set & eis_pkg::STATUS_IMPL);
        st_nxt.status[eis_pkg::BIT_XCVR] = events.transceiver_event;
        // read channel
        if (st_r.rvalid && axi_req.rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (do_read) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = mapped({axi_req.araddr[7:2], 2'b00}) ? eis_pkg::RESP_OKAY : eis_pkg::RESP_SLVERR;
            case ({axi_req.araddr[7:2], 2'b00})
                eis_pkg::OFS_IRQ_CFG:   st_nxt.rdata = cfg_word;
                eis_pkg::OFS_STATUS:    st_nxt.rdata = st_r.status & eis_pkg::STATUS_IMPL;
                eis_pkg::OFS_ENABLE:    st_nxt.rdata = st_r.enable;
                eis_pkg::OFS_BYTE_TEST: st_nxt.rdata = eis_pkg::BYTE_TEST_VAL;
                default:                st_nxt.rdata = 32'h00000000;
            endcase
        end
        // request pin gated by global enable and the hold-off window
        st_nxt.irq     = st_r.irq_en && any_irq && !holdoff_active;
        // power interrupt ignores the hold-off window
        st_nxt.pwr_irq = st_r.irq_en && st_r.status[eis_pkg::BIT_PWR] &&
                         st_r.enable[eis_pkg::BIT_PWR];
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r        <= '0;
            st_r.status <= eis_pkg::STATUS_RST;
            st_r.enable <= eis_pkg::ENABLE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign axi_awready       = !st_r.aw_got;
    assign axi_wready        = !st_r.w_got;
    assign axi_bvalid        = st_r.bvalid;
    assign axi_bresp         = st_r.bresp;
    assign axi_arready       = !st_r.rvalid;
    assign axi_rvalid        = st_r.rvalid;
    assign axi_rdata         = st_r.rdata;
    assign axi_rresp         = st_r.rresp;
    assign irq_request       = st_r.irq;
    assign power_irq_request = st_r.pwr_irq;
    assign wake_request      = st_r.wake;
endmodule // eis_status

// [verification/eis_props.sv]
// concurrent checks on the port behaviour of the status collector
// assumes attachment by the bind below; sees only the collector's ports
module eis_props (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire eis_pkg::eis_axi_req_s axi_req,
    input wire logic                  axi_awready,
    input wire logic                  axi_wready,
    input wire logic                  axi_bvalid,
    input wire logic [1:0]            axi_bresp,
    input wire logic                  axi_arready,
    input wire logic                  axi_rvalid,
    input wire logic [31:0]           axi_rdata,
    input wire logic [1:0]            axi_rresp,
    input wire eis_pkg::eis_events_s  events,
    input wire logic                  holdoff_active,
    input wire logic                  irq_request,
    input wire logic                  power_irq_request,
    input wire logic                  wake_request
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // write taken whole in one edge, answered two edges later
    sequence s_wr_taken;
        axi_req.awvalid && axi_awready && axi_req.wvalid && axi_wready;
    endsequence
    sequence s_wr_answer;
        ##1 !axi_bvalid ##1 axi_bvalid;
    endsequence

    a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
        else $error("write answer not two edges after take");
    a_read_answer: assert property (axi_req.arvalid && axi_arready |=> axi_rvalid)
        else $error("read answer missing");
    a_bresp_held: assert property (axi_bvalid && !axi_req.bready |=> axi_bvalid && $stable(axi_bresp))
        else $error("write answer dropped early");
    a_rdata_held: assert property (axi_rvalid && !axi_req.rready |=> axi_rvalid && $stable(axi_rdata))
        else $error("read answer dropped early");
    a_read_busy: assert property (axi_rvalid |-> !axi_arready)
        else $error("read taken while answer pending");
    a_unmapped_zero: assert property (axi_rvalid && axi_rresp == eis_pkg::RESP_SLVERR |-> axi_rdata == 32'h0)
        else $error("unmapped read returns data");
    a_holdoff_block: assert property (holdoff_active |=> !irq_request)
        else $error("request line up during hold-off");
    a_wake_pulse: assert property (wake_request |=> !wake_request)
        else $error("wake longer than one cycle");
    a_wake_cause: assert property (wake_request |-> axi_bvalid || $past(axi_bvalid))
        else $error("wake without a host write");
endmodule // eis_props

bind eis_status eis_props u_props (.aclk, .aresetn, .axi_req, .axi_awready, .axi_wready, .axi_bvalid, .axi_bresp,
    .axi_arready, .axi_rvalid, .axi_rdata, .axi_rresp, .events, .holdoff_active, .irq_request, .power_irq_request,
    .wake_request);

// [verification/eis_host_model.sv]
// host cpu model: axi4-lite master, one access at a time
// assumes req feeds the collector and rsp gathers its answers
module eis_host_model (
    input  wire logic                  aclk,
    output eis_pkg::eis_axi_req_s      req,
    input  wire eis_pkg::eis_axi_rsp_s rsp
);
    initial req = '0;

    // ready raised only after the answer shows, so the slave must hold it; answer code 3 marks a timeout
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic go;
        go = 1'b1;
        r = 2'h3;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        for (int n = 0; n < 40 && go; n++) begin
            @(posedge aclk);
            // each half released at the edge that takes it, answer taken at its own edge
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) begin
                r = rsp.bresp;
                go = 1'b0;
            end
            req.bready <= rsp.bvalid && go;
        end
    endtask

    // read with the same late ready
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic go;
        go = 1'b1;
        r = 2'h3;
        d = '0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        for (int n = 0; n < 40 && go; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                d = rsp.rdata;
                r = rsp.rresp;
                go = 1'b0;
            end
            req.rready <= rsp.rvalid && go;
        end
    endtask
endmodule // eis_host_model

// [verification/ethernet_interrupt_status_tb.sv]
// self-checking bench for the interrupt status collector
// assumes the host model drives the register bus; events come from here
module ethernet_interrupt_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  aclk = 1'b0;
    logic                  aresetn = 1'b0;
    logic                  holdoff_active = 1'b0;
    logic                  irq_request;
    logic                  power_irq_request;
    logic                  wake_request;
    eis_pkg::eis_axi_req_s axi_req;
    wire eis_pkg::eis_axi_rsp_s rsp;
    eis_pkg::eis_events_s  ev = '0;
    int                    mismatches = 0;
    int                    compares = 0;
    int                    wakes = 0;

    always #2 aclk = ~aclk;
    // wake pulses counted so a missing or extra one shows
    always @(posedge aclk) if (wake_request === 1'b1) wakes <= wakes + 1;

    eis_host_model h (.aclk(aclk), .req(axi_req), .rsp(rsp));
    eis_status uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_awready(rsp.awready),
        .axi_wready(rsp.wready), .axi_bvalid(rsp.bvalid), .axi_bresp(rsp.bresp), .axi_arready(rsp.arready),
        .axi_rvalid(rsp.rvalid), .axi_rdata(rsp.rdata), .axi_rresp(rsp.rresp), .events(ev),
        .holdoff_active(holdoff_active), .irq_request(irq_request), .power_irq_request(power_irq_request),
        .wake_request(wake_request));

    task automatic stop_test;
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = eis_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        h.rd(a, d, r);
        chk({30'h0, er}, {30'h0, r});
        chk(exp, d);
        // code 3 means the bus wait ran out: already counted, end here
        if (r === 2'h3) stop_test();
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = eis_pkg::RESP_OKAY);
        logic [1:0] r;
        h.wr(a, d, r);
        chk({30'h0, er}, {30'h0, r});
        if (r === 2'h3) stop_test();
    endtask
    // one-cycle event, seen in status, cleared by writing its ones, then gone
    task automatic one(input eis_pkg::eis_events_s e, input logic [31:0] exp);
        @(posedge aclk);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        rchk(eis_pkg::OFS_STATUS, exp);
        wchk(eis_pkg::OFS_STATUS, exp);
        rchk(eis_pkg::OFS_STATUS, 32'h0);
    endtask

    task automatic t_reset;
        rchk(eis_pkg::OFS_STATUS, 32'h0);
        rchk(eis_pkg::OFS_ENABLE, 32'h0);
        rchk(eis_pkg::OFS_BYTE_TEST, 32'h87654321);
        rchk(8'h60, 32'h0, eis_pkg::RESP_SLVERR);
        wchk(8'h60, 32'hFFFFFFFF, eis_pkg::RESP_SLVERR);
    endtask
    // every source except the transceiver mirror and io line 1, with the mask clear; boundary cases must not set
    task automatic t_sources;
        one('{software_event_trigger: 1'b1, default: '0}, 32'h80000000);
        one('{tx_halted: 1'b1, default: '0}, 32'h0);
        one('{tx_stop_requested: 1'b1, tx_halted: 1'b1, rx_halted: 1'b1, default: '0}, 32'h03000000);
        one('{drop_count_inc: 1'b1, drop_count: 32'h7FFFFFFE, default: '0}, 32'h0);
        one('{drop_count_inc: 1'b1, drop_count: 32'h7FFFFFFF, default: '0}, 32'h00800000);
        one('{transmit_buffer_loaded: 1'b1, default: '0}, 32'h0);
        one('{transmit_buffer_loaded: 1'b1, completion_notify_flag: 1'b1, default: '0}, 32'h00200000);
        one('{receive_dma_count_done: 1'b1, tx_status_overflow: 1'b1, default: '0}, 32'h00110000);
        one('{timer_tick: 1'b1, timer_count: 16'h0001, default: '0}, 32'h0);
        one('{timer_tick: 1'b1, power_event: 1'b1, default: '0}, 32'h000A0000);
        one('{rx_packet_end: 1'b1, rx_packet_bytes: 16'h0800, tx_data_write: 1'b1, default: '0}, 32'h0);
        one('{rx_packet_end: 1'b1, rx_packet_bytes: 16'h0801, default: '0}, 32'h00008000);
        one('{tx_data_write: 1'b1, tx_data_full: 1'b1, rx_error: 1'b1, tx_error: 1'b1, default: '0}, 32'h6400);
        one('{tx_space_above_level: 1'b1, tx_status_full: 1'b1, tx_status_at_level: 1'b1, default: '0}, 32'h380);
        one('{frame_dropped: 1'b1, rx_status_full: 1'b1, rx_status_at_level: 1'b1, default: '0}, 32'h58);
        one('{io_line_events: 3'h5, default: '0}, 32'h5);
    endtask
    // writing zero bits and the read-only mirror leave bits alone
    task automatic t_partial;
        ev <= '{rx_error: 1'b1, tx_error: 1'b1, transceiver_event: 1'b1, default: '0};
        @(posedge aclk);
        ev <= '{transceiver_event: 1'b1, default: '0};
        wchk(eis_pkg::OFS_STATUS, 32'h00044000);
        rchk(eis_pkg::OFS_STATUS, 32'h00042000);
        ev <= '0;
        wchk(eis_pkg::OFS_STATUS, 32'h00002000);
        rchk(eis_pkg::OFS_STATUS, 32'h0);
    endtask
    // mask, global enable, hold-off, power bypass, wake
    task automatic t_irq;
        wchk(eis_pkg::OFS_ENABLE, 32'hFFFFFFFF);
        rchk(eis_pkg::OFS_ENABLE, 32'h83BFE7DF);
        wchk(eis_pkg::OFS_ENABLE, 32'h01020000);
        wchk(eis_pkg::OFS_IRQ_CFG, 32'h00000100);
        // masked timer bit pending with the pin enabled: master and pin stay low
        ev <= '{timer_tick: 1'b1, default: '0};
        @(posedge aclk);
        ev <= '0;
        rchk(eis_pkg::OFS_IRQ_CFG, 32'h00000100);
        chk(32'h0, {31'h0, irq_request});
        rchk(eis_pkg::OFS_STATUS, 32'h00080000);
        wchk(eis_pkg::OFS_STATUS, 32'h00080000);
        ev <= '{rx_halted: 1'b1, default: '0};
        holdoff_active <= 1'b1;
        @(posedge aclk);
        ev <= '{power_event: 1'b1, default: '0};
        @(posedge aclk);
        ev <= '0;
        rchk(eis_pkg::OFS_IRQ_CFG, 32'h00001100);
        chk(32'h0, {31'h0, irq_request});
        chk(32'h1, {31'h0, power_irq_request});
        chk(32'(wakes), 32'h0);
        holdoff_active <= 1'b0;
        wchk(eis_pkg::OFS_BYTE_TEST, 32'h0);
        chk(32'h1, {31'h0, irq_request});
        chk(32'(wakes), 32'h1);
        wchk(eis_pkg::OFS_IRQ_CFG, 32'h0);
        chk(32'h0, {30'h0, irq_request, power_irq_request});
        rchk(eis_pkg::OFS_STATUS, 32'h01020000);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_sources();
        t_partial();
        t_irq();
        stop_test();
    end
    // hang guard
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
endmodule // ethernet_interrupt_status_tb
